// *** lcdft_checker.sv ***
// port-level checks of the lcd frame timing block
`timescale 1ns/100ps
`default_nettype none
`include "lcdft_defines.vh"

module lcdft_checker (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [31:0] wb_adr_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        line_clk,
  input wire logic        frame_marker_out,
  input wire logic        bias_on,
  input wire logic        fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic        fetch_ack
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // bus and fetch steps
  sequence s_bus_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_ack;
    wb_ack_o && !wb_we_i;
  endsequence
  sequence s_fetch_take;
    fetch_req && fetch_ack;
  endsequence
  AST_ACK_NEXT: assert property (s_bus_take |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_LCW_RSV: assert property (s_rd_ack ##0 (wb_adr_i[31:2] == `LCDFT_IDX_LCW)
    |-> (wb_dat_o & 32'hffffc0c0) == 32'h0) else $error("line clock reserved bits set");
  AST_FBS_RO: assert property (s_rd_ack ##0 (wb_adr_i[31:2] == `LCDFT_IDX_FBS_HI)
    |-> (wb_dat_o & 32'hffffe000) == 32'h0) else $error("start address top bits set");
  AST_FBE_RO: assert property (s_rd_ack ##0 (wb_adr_i[31:2] == `LCDFT_IDX_FBE_HI)
    |-> (wb_dat_o & 32'hffffe000) == 32'h0) else $error("end address top bits set");
  AST_FM_RSV: assert property (s_rd_ack ##0 (wb_adr_i[31:2] == `LCDFT_IDX_FM_FIRST ||
    wb_adr_i[31:2] == `LCDFT_IDX_FM_SECOND) |-> wb_dat_o[31:8] == 24'h0)
    else $error("marker reserved bits set");
  AST_FETCH_HOLD: assert property (fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request not held");
  AST_FETCH_DROP: assert property (s_fetch_take |=> !fetch_req)
    else $error("fetch request not dropped after ack");
  AST_RESET_OUT: assert property ($fell(srst) |-> !line_clk && !frame_marker_out && !bias_on
    && !fetch_req) else $error("output active out of reset");
endmodule

bind lcdft_timing lcdft_checker u_chk (
  .core_clk(core_clk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .line_clk(line_clk), .frame_marker_out(frame_marker_out), .bias_on(bias_on),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack)
);
`default_nettype wire

// *** lcdft_defines.vh ***
// register map, field positions and constants of the lcd frame timing block
`ifndef LCDFT_DEFINES_VH
`define LCDFT_DEFINES_VH

// register indices; byte address is four times the index
`define LCDFT_IDX_CTRL      30'h0a000414
`define LCDFT_IDX_LCW       30'h0a000416
`define LCDFT_IDX_FBS_LO    30'h0a000418
`define LCDFT_IDX_FBS_HI    30'h0a00041a
`define LCDFT_IDX_FBE_LO    30'h0a000420
`define LCDFT_IDX_FBE_HI    30'h0a000422
`define LCDFT_IDX_FM_FIRST  30'h0a000424
`define LCDFT_IDX_FM_SECOND 30'h0a000426
`define LCDFT_IDX_BIAS      30'h0a000430
`define LCDFT_IDX_STATUS    30'h0a000440
`define LCDFT_IDX_FETCH     30'h0a000444

// field positions
`define LCDFT_LOW_MSB   13
`define LCDFT_LOW_LSB   8
`define LCDFT_HIGH_MSB  5
`define LCDFT_HIGH_LSB  0
`define LCDFT_PRE_MSB   5
`define LCDFT_PRE_LSB   4
`define LCDFT_EN_BIT    0
`define LCDFT_BIAS_MSB  4
`define LCDFT_AHI_MSB   12

// prescaler codes
`define LCDFT_DIV1      2'h0
`define LCDFT_DIV2      2'h1
`define LCDFT_DIV4      2'h2

// constants
`define LCDFT_ZERO16    16'h0000
`define LCDFT_WORD_STEP 32'h00000004
`define LCDFT_ONE6      6'h01
`define LCDFT_MAX_FRAME 5'h1f

`endif

// *** lcdft_fifo.v ***
// synchronous fifo for fetched frame buffer words
`timescale 1ns/100ps
`default_nettype none

module lcdft_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             core_clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      fill;
  wire            push;
  wire            pop;

  // honest full and empty from the fill count
  assign in_ready  = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always @(posedge core_clk) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        fill <= fill + 1'b1;
      end else if (pop & ~push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** lcdft_mem_model.sv ***
// frame buffer memory answering word fetches
`timescale 1ns/100ps
`default_nettype none

module lcdft_mem_model (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  input  wire logic [3:0]  delay,
  output var  logic        fetch_ack,
  output var  logic [31:0] fetch_data
);
  logic [3:0] wait_cnt;
  // packed word per address
  // answer after delay cycles, data churns when idle
  always @(posedge core_clk) begin
    if (srst) begin
      fetch_ack <= 1'h0;
      fetch_data <= 32'h0;
      wait_cnt <= 4'h0;
    end else if (fetch_req && !fetch_ack && wait_cnt >= delay) begin
      fetch_ack <= 1'h1;
      fetch_data <= {fetch_addr[15:0], ~fetch_addr[15:0]};
      wait_cnt <= 4'h0;
    end else begin
      fetch_ack <= 1'h0;
      fetch_data <= ~fetch_data;
      if (fetch_req && !fetch_ack)
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** lcdft_tb.sv ***
// self-checking bench for the lcd frame timing block
`timescale 1ns/100ps
`default_nettype none
`include "lcdft_defines.vh"

module testbench;
  typedef struct {logic [29:0] idx; logic [31:0] wd; logic [31:0] rd;} lcdft_row_t;
  logic             core_clk, srst, wb_we_i, wb_cyc_i, wb_stb_i, pix_ready;
  logic [31:0]      wb_adr_i, wb_dat_i, q, a;
  logic [3:0]       wb_sel_i, delay;
  wire logic [31:0] wb_dat_o, fetch_addr, fetch_data, pix_data;
  wire logic        wb_ack_o, line_clk, frame_marker_out, bias_on, fetch_req, fetch_ack;
  wire logic        pix_valid;
  int               n_fail, check_count, n, k, t;
  lcdft_row_t rows [9] = '{
    '{`LCDFT_IDX_LCW, 32'hffff, 32'h3f3f}, '{`LCDFT_IDX_FBS_LO, 32'hfff8, 32'hfff8},
    '{`LCDFT_IDX_FBS_HI, 32'hffff, 32'h1fff}, '{`LCDFT_IDX_FBE_LO, 32'hffff, 32'hffff},
    '{`LCDFT_IDX_FBE_HI, 32'hffff, 32'h1fff}, '{`LCDFT_IDX_FM_FIRST, 32'hffff, 32'h00ff},
    '{`LCDFT_IDX_FM_SECOND, 32'hffff, 32'h00ff}, '{`LCDFT_IDX_BIAS, 32'hffff, 32'h001f},
    '{30'h0a000450, 32'hffff, 32'h0}};

  lcdft_timing #(.LINE_LEN(8), .FRAME_LINES(4)) dut (
    .core_clk(core_clk), .srst(srst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .line_clk(line_clk),
    .frame_marker_out(frame_marker_out), .bias_on(bias_on), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .pix_data(pix_data), .pix_valid(pix_valid), .pix_ready(pix_ready));
  lcdft_mem_model u_mem (
    .core_clk(core_clk), .srst(srst), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .delay(delay), .fetch_ack(fetch_ack), .fetch_data(fetch_data));

  // clock
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic bus cycle, waits for ack
  task automatic wb(input logic w, input logic [29:0] idx, input logic [31:0] d,
                    output logic [31:0] r);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // no own limit: only the watchdog ends a missing answer
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'h1);
    r = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge core_clk);
  endtask

  function automatic logic sig(input int s);
    return s ? frame_marker_out : line_clk;
  endfunction

  // length in cycles of the next whole phase at level lvl
  task automatic measure(input int s, input logic lvl, output int len);
    int c;
    len = 0;
    c = 0;
    while (sig(s) === lvl && c < 2000) begin @(posedge core_clk); c++; end
    while (sig(s) !== lvl && c < 2000) begin @(posedge core_clk); c++; end
    while (sig(s) === lvl && c < 2000) begin @(posedge core_clk); c++; len++; end
  endtask

  task summarize;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // cut a hang short
  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    summarize();
  end

  // main sequence
  initial begin
    srst = 1'h1;
    wb_we_i = 1'h0;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    pix_ready = 1'h0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    delay = 4'h0;
    repeat (10) @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      wb(1'h0, rows[i].idx, 32'h0, q);
      chk("reset value", 32'h0, q);
    end
    foreach (rows[i]) begin
      wb(1'h1, rows[i].idx, rows[i].wd, q);
      wb(1'h0, rows[i].idx, 32'h0, q);
      chk("read back", rows[i].rd, q);
    end
    // fetch window, marker edges, bias frame, widths 3 low 5 high
    wb(1'h1, `LCDFT_IDX_FBS_LO, 32'h0100, q);
    wb(1'h1, `LCDFT_IDX_FBS_HI, 32'h0, q);
    wb(1'h1, `LCDFT_IDX_FBE_LO, 32'h0118, q);
    wb(1'h1, `LCDFT_IDX_FBE_HI, 32'h0, q);
    wb(1'h1, `LCDFT_IDX_FM_FIRST, 32'h2, q);
    wb(1'h1, `LCDFT_IDX_FM_SECOND, 32'h5, q);
    wb(1'h1, `LCDFT_IDX_BIAS, 32'h2, q);
    wb(1'h1, `LCDFT_IDX_LCW, 32'h0305, q);
    // each prescaler code scales both widths; reserved code runs as divide by four
    for (int p = 0; p < 4; p++) begin
      wb(1'h1, `LCDFT_IDX_CTRL, 32'h1 | (32'(p) << 4), q);
      if (p == 0)
        chk("bias early", 32'h0, {31'h0, bias_on});
      measure(0, 1'h0, n);
      chk("low width", 32'h3 << (p == 3 ? 2 : p), n);
      measure(0, 1'h1, n);
      chk("high width", 32'h5 << (p == 3 ? 2 : p), n);
    end
    wb(1'h1, `LCDFT_IDX_CTRL, 32'h1, q);
    wb(1'h1, `LCDFT_IDX_LCW, 32'h0101, q);
    measure(1, 1'h1, n);
    chk("marker high", 32'h6, n);
    measure(1, 1'h0, n);
    chk("marker low", 32'h3a, n);
    chk("bias late", 32'h1, {31'h0, bias_on});
    // panel stalled all along: fifo full, no request open
    chk("fetch while full", 32'h0, {31'h0, fetch_req});
    chk("fifo holds data", 32'h1, {31'h0, pix_valid});
    // eight words taken: seven up to the end, wrap, one more from the start
    wb(1'h0, `LCDFT_IDX_FETCH, 32'h0, q);
    chk("fetch address", 32'h104, q);
    wb(1'h0, `LCDFT_IDX_STATUS, 32'h0, q);
    chk("status bias", 32'h1, {31'h0, q[14]});
    wb(1'h0, `LCDFT_IDX_CTRL, 32'h0, q);
    chk("control", 32'h1, q);
    delay <= 4'h3;
    pix_ready <= 1'h1;
    a = 32'h100;
    k = 0;
    t = 0;
    while (k < 20 && t < 2000) begin
      @(posedge core_clk);
      t++;
      if (pix_valid === 1'h1) begin
        chk("pixel word", {a[15:0], ~a[15:0]}, pix_data);
        a = (a >= 32'h118) ? 32'h100 : a + 32'h4;
        k++;
      end
    end
    chk("pixel count", 32'h14, k);
    // reset in mid-run while words are being fetched
    srst <= 1'h1;
    repeat (3) @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    chk("line clock after reset", 32'h0, {31'h0, line_clk});
    chk("marker after reset", 32'h0, {31'h0, frame_marker_out});
    chk("bias after reset", 32'h0, {31'h0, bias_on});
    chk("fetch after reset", 32'h0, {31'h0, fetch_req});
    chk("fifo after reset", 32'h0, {31'h0, pix_valid});
    wb(1'h0, `LCDFT_IDX_FBS_LO, 32'h0, q);
    chk("start after reset", 32'h0, q);
    wb(1'h0, `LCDFT_IDX_FM_FIRST, 32'h0, q);
    chk("marker after reset", 32'h0, q);
    wb(1'h0, `LCDFT_IDX_FETCH, 32'h0, q);
    chk("fetch address after reset", 32'h0, q);
    summarize();
  end
endmodule
`default_nettype wire

// *** lcdft_timing.v ***
// lcd frame timing: registers, line clock, frame marker, bias and fetch
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lcdft_defines.vh"

module lcdft_timing #(
  parameter LINE_LEN    = 200,
  parameter FRAME_LINES = 240,
  parameter FIFO_DEPTH  = 8,
  parameter FIFO_AW     = 3
) (
  input  wire        core_clk,
  input  wire        srst,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  output reg         line_clk,
  output reg         frame_marker_out,
  output reg         bias_on,
  output reg         fetch_req,
  output reg  [31:0] fetch_addr,
  input  wire        fetch_ack,
  input  wire [31:0] fetch_data,
  output wire [31:0] pix_data,
  output wire        pix_valid,
  input  wire        pix_ready
);

  // register contents
  reg  [15:0] ctrl;
  reg  [5:0]  line_clock_low_count;
  reg  [5:0]  line_clock_high_count;
  reg  [15:0] fbs_lo;
  reg  [12:0] fbs_hi;
  reg  [15:0] fbe_lo;
  reg  [12:0] fbe_hi;
  reg  [7:0]  frame_marker_first_x;
  reg  [7:0]  frame_marker_second_x;
  reg  [4:0]  bias_count;

  // timing state
  reg  [1:0]  div_cnt;
  reg         gclk_en;
  reg  [5:0]  phase_cnt;
  reg  [7:0]  hpos;
  reg  [9:0]  vline;
  reg  [4:0]  frame_cnt;
  reg         en_d;

  wire        bus_req;
  wire        wr_en;
  wire [29:0] widx;
  wire        enable;
  wire [1:0]  prescale;
  wire [31:0] fb_start_address;
  wire [31:0] fb_end_address;
  wire [5:0]  low_len;
  wire [5:0]  high_len;
  wire        phase_done;
  wire        line_tick;
  wire        line_last;
  wire        frame_last;
  wire        fifo_in_ready;
  reg  [31:0] next_rdata;
  reg         next_gclk_en;

  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en    = bus_req & wb_we_i;
  assign widx     = wb_adr_i[31:2];
  assign enable   = ctrl[`LCDFT_EN_BIT];
  assign prescale = ctrl[`LCDFT_PRE_MSB:`LCDFT_PRE_LSB];

  // top three bits held at zero
  assign fb_start_address = {3'h0, fbs_hi, fbs_lo};
  // top three bits held at zero
  assign fb_end_address   = {3'h0, fbe_hi, fbe_lo};

  // ------------------------------------------------------------------
  // wishbone slave: one wait state, ack for one cycle
  // ------------------------------------------------------------------

  // bus acknowledge, also for unmapped addresses
  always @(posedge core_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // register writes with byte lane enables
  always @(posedge core_clk) begin
    if (srst) begin
      ctrl                  <= `LCDFT_ZERO16;
      line_clock_low_count  <= 6'h00;
      line_clock_high_count <= 6'h00;
      fbs_lo                <= `LCDFT_ZERO16;
      fbs_hi                <= 13'h0000;
      fbe_lo                <= `LCDFT_ZERO16;
      fbe_hi                <= 13'h0000;
      frame_marker_first_x  <= 8'h00;
      frame_marker_second_x <= 8'h00;
      bias_count            <= 5'h00;
    end else if (wr_en) begin
      case (widx)
        `LCDFT_IDX_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl[7:0] <= {2'h0, wb_dat_i[5:4], 3'h0, wb_dat_i[0]};
          end
        end
        `LCDFT_IDX_LCW: begin
          if (wb_sel_i[1]) begin
            line_clock_low_count <= wb_dat_i[`LCDFT_LOW_MSB:`LCDFT_LOW_LSB];
          end
          if (wb_sel_i[0]) begin
            line_clock_high_count <= wb_dat_i[`LCDFT_HIGH_MSB:`LCDFT_HIGH_LSB];
          end
        end
        `LCDFT_IDX_FBS_LO: begin
          if (wb_sel_i[1]) begin
            fbs_lo[15:8] <= wb_dat_i[15:8];
          end
          if (wb_sel_i[0]) begin
            fbs_lo[7:0] <= wb_dat_i[7:0];
          end
        end
        `LCDFT_IDX_FBS_HI: begin
          if (wb_sel_i[1]) begin
            fbs_hi[12:8] <= wb_dat_i[`LCDFT_AHI_MSB:8];
          end
          if (wb_sel_i[0]) begin
            fbs_hi[7:0] <= wb_dat_i[7:0];
          end
        end
        `LCDFT_IDX_FBE_LO: begin
          if (wb_sel_i[1]) begin
            fbe_lo[15:8] <= wb_dat_i[15:8];
          end
          if (wb_sel_i[0]) begin
            fbe_lo[7:0] <= wb_dat_i[7:0];
          end
        end
        `LCDFT_IDX_FBE_HI: begin
          if (wb_sel_i[1]) begin
            fbe_hi[12:8] <= wb_dat_i[`LCDFT_AHI_MSB:8];
          end
          if (wb_sel_i[0]) begin
            fbe_hi[7:0] <= wb_dat_i[7:0];
          end
        end
        `LCDFT_IDX_FM_FIRST: begin
          if (wb_sel_i[0]) begin
            frame_marker_first_x <= wb_dat_i[7:0];
          end
        end
        `LCDFT_IDX_FM_SECOND: begin
          if (wb_sel_i[0]) begin
            frame_marker_second_x <= wb_dat_i[7:0];
          end
        end
        `LCDFT_IDX_BIAS: begin
          if (wb_sel_i[0]) begin
            bias_count <= wb_dat_i[`LCDFT_BIAS_MSB:0];
          end
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // read mux; reserved and unmapped bits read zero
  always @* begin
    next_rdata = 32'h00000000;
    case (widx)
      `LCDFT_IDX_CTRL:      next_rdata[15:0] = ctrl;
      `LCDFT_IDX_LCW:       next_rdata[15:0] = {2'h0, line_clock_low_count,
                                                2'h0, line_clock_high_count};
      `LCDFT_IDX_FBS_LO:    next_rdata[15:0] = fbs_lo;
      `LCDFT_IDX_FBS_HI:    next_rdata[15:0] = fb_start_address[31:16];
      `LCDFT_IDX_FBE_LO:    next_rdata[15:0] = fbe_lo;
      `LCDFT_IDX_FBE_HI:    next_rdata[15:0] = fb_end_address[31:16];
      `LCDFT_IDX_FM_FIRST:  next_rdata[15:0] = {8'h00, frame_marker_first_x};
      `LCDFT_IDX_FM_SECOND: next_rdata[15:0] = {8'h00, frame_marker_second_x};
      `LCDFT_IDX_BIAS:      next_rdata[15:0] = {11'h000, bias_count};
      `LCDFT_IDX_STATUS:    next_rdata[15:0] = {frame_marker_out, bias_on,
                                                line_clk, frame_cnt, 8'h00};
      `LCDFT_IDX_FETCH:     next_rdata = fetch_addr;
      default:              next_rdata = 32'h00000000;
    endcase
  end

  // read data registered with the ack
  always @(posedge core_clk) begin
    if (srst) begin
      wb_dat_o <= 32'h00000000;
    end else if (bus_req & ~wb_we_i) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // base clock enable
  // ------------------------------------------------------------------

  // divide by 1, 2 or 4; reserved code acts as 4
  always @* begin
    case (prescale)
      `LCDFT_DIV1: next_gclk_en = 1'b1;
      `LCDFT_DIV2: next_gclk_en = div_cnt[0];
      `LCDFT_DIV4: next_gclk_en = &div_cnt;
      default:     next_gclk_en = &div_cnt;
    endcase
  end

  // free running divider counter
  always @(posedge core_clk) begin
    if (srst) begin
      div_cnt <= 2'h0;
      gclk_en <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
      gclk_en <= next_gclk_en & enable;
    end
  end

  // ------------------------------------------------------------------
  // line clock and raster position
  // ------------------------------------------------------------------

  // a zero width still lasts one base clock
  assign low_len    = (line_clock_low_count == 6'h00) ? `LCDFT_ONE6 : line_clock_low_count;
  assign high_len   = (line_clock_high_count == 6'h00) ? `LCDFT_ONE6 : line_clock_high_count;
  assign phase_done = line_clk ? (phase_cnt + `LCDFT_ONE6 >= high_len)
                               : (phase_cnt + `LCDFT_ONE6 >= low_len);
  assign line_tick  = gclk_en & phase_done & ~line_clk;
  assign line_last  = (hpos == LINE_LEN[7:0] - 8'h01);
  assign frame_last = (vline == FRAME_LINES[9:0] - 10'h001);

  // line clock phase counter
  always @(posedge core_clk) begin
    if (srst | ~enable) begin
      line_clk  <= 1'b0;
      phase_cnt <= 6'h00;
    end else if (gclk_en) begin
      if (phase_done) begin
        line_clk  <= ~line_clk;
        phase_cnt <= 6'h00;
      end else begin
        phase_cnt <= phase_cnt + `LCDFT_ONE6;
      end
    end
  end

  // horizontal position in pixel pairs and line number
  always @(posedge core_clk) begin
    if (srst | ~enable) begin
      hpos  <= 8'h00;
      vline <= 10'h000;
    end else if (line_tick) begin
      if (line_last) begin
        hpos  <= 8'h00;
        vline <= frame_last ? 10'h000 : vline + 10'h001;
      end else begin
        hpos <= hpos + 8'h01;
      end
    end
  end

  // frame marker during the first line of a frame
  always @(posedge core_clk) begin
    if (srst | ~enable) begin
      frame_marker_out <= 1'b0;
    end else if (line_tick) begin
      if (vline != 10'h000) begin
        frame_marker_out <= 1'b0;
      end else if (hpos == frame_marker_first_x) begin
        frame_marker_out <= 1'b1;
      end else if (hpos == frame_marker_second_x) begin
        frame_marker_out <= 1'b0;
      end
    end
  end

  // frame counter for power sequencing
  always @(posedge core_clk) begin
    if (srst | ~enable) begin
      frame_cnt <= 5'h00;
      bias_on   <= 1'b0;
    end else begin
      if (line_tick & line_last & frame_last & (frame_cnt != `LCDFT_MAX_FRAME)) begin
        frame_cnt <= frame_cnt + 5'h01;
      end
      bias_on <= (frame_cnt >= bias_count);
    end
  end

  // ------------------------------------------------------------------
  // frame buffer fetch into the fifo
  // ------------------------------------------------------------------

  // request words while the fifo has room
  always @(posedge core_clk) begin
    if (srst) begin
      en_d       <= 1'b0;
      fetch_req  <= 1'b0;
      fetch_addr <= 32'h00000000;
    end else begin
      en_d <= enable;
      if (enable & ~en_d) begin
        fetch_addr <= {fb_start_address[31:3], 3'h0};
        fetch_req  <= 1'b0;
      end else if (~enable) begin
        fetch_req <= 1'b0;
      end else if (fetch_req & fetch_ack) begin
        fetch_req <= 1'b0;
        if (fetch_addr[31:3] >= fb_end_address[31:3]) begin
          // wrap to start for next frame
          fetch_addr <= {fb_start_address[31:3], 3'h0};
        end else begin
          fetch_addr <= fetch_addr + `LCDFT_WORD_STEP;
        end
      end else if (fifo_in_ready & en_d) begin
        fetch_req <= 1'b1;
      end
    end
  end

  // word buffer between memory and pixel path
  lcdft_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_data   (fetch_data),
    .in_valid  (fetch_req & fetch_ack),
    .in_ready  (fifo_in_ready),
    .out_data  (pix_data),
    .out_valid (pix_valid),
    .out_ready (pix_ready)
  );

endmodule

`default_nettype wire
